// ==== design/fan_mon_pkg.sv ====
`default_nettype none
package fan_mon_pkg;
	localparam logic [7:0]  OFF_CTRL = 8'h00;
	localparam logic [7:0]  OFF_STAT = 8'h04;
	localparam logic [7:0]  OFF_HIGH = 8'h08;
	localparam logic [7:0]  OFF_LOW  = 8'h0c;
	localparam int          READ_LSB = 16;
	localparam int          BIT_IN_EN = 15;
	localparam int          BIT_RDY_EN = 14;
	localparam int          EDGE_LSB = 11;
	localparam int          BIT_MODE = 10;
	localparam int          BIT_FILT = 8;
	localparam int          BIT_EN = 1;
	localparam int          BIT_LIM_EN = 0;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] HIGH_RST = 16'hffff;
	localparam logic [15:0] LOW_RST = 16'h0000;
	localparam logic [3:0]  EDGES_SEL0 = 4'h2;
	localparam logic [3:0]  EDGES_SEL1 = 4'h3;
	localparam logic [3:0]  EDGES_SEL2 = 4'h5;
	localparam logic [3:0]  EDGES_SEL3 = 4'h9;
	localparam logic [3:0]  EDGE_ONE = 4'h1;
	localparam int          SYS_PERIOD_NS = 10;
	localparam int          REF_PERIOD_NS = 10000;
	localparam int          REF_DIV = (REF_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [1:0]  FILT_TICKS = 2'h2;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       in_en;
		logic       rdy_en;
		logic [1:0] edges;
		logic       mode;
		logic       filt;
		logic       en;
		logic       lim_en;
	} ctrl_s;

	typedef struct packed {
		logic tog;
		logic rdy;
		logic lim;
	} stat_s;

	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_WAIT = 3'b010,
		M_GATE = 3'b100
	} meas_e;

	function automatic logic [3:0] edges_target(input logic [1:0] sel);
		case (sel)
			2'h0: edges_target = EDGES_SEL0;
			2'h1: edges_target = EDGES_SEL1;
			2'h2: edges_target = EDGES_SEL2;
			default: edges_target = EDGES_SEL3;
		endcase
	endfunction
endpackage
`default_nettype wire

// ==== design/ref_tick_div.sv ====
`timescale 1ns/1ns
`default_nettype none
module ref_tick_div #(
	parameter int DIV = 1000
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	output logic      tick
);
	logic [15:0] cnt;
	wire         last = (cnt == 16'(DIV - 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cnt <= 16'h0000;
		else
			cnt <= last ? 16'h0000 : cnt + 16'h0001;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			tick <= 1'b0;
		else
			tick <= last;
	end
endmodule
`default_nettype wire

// ==== design/fan_edge_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module fan_edge_sync
	import fan_mon_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic tick,
	input  wire logic fan_in,
	output logic      raw_rise,
	output logic      raw_toggle,
	output logic      filt_rise
);
	logic       s1;
	logic       s2;
	logic       s3;
	logic       flvl;
	logic       fprev;
	logic [1:0] stable;

	// s1 feeds s2 only; edges are taken after the second stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			fprev <= 1'b0;
		end else begin
			s1 <= fan_in;
			s2 <= s1;
			s3 <= s2;
			fprev <= flvl;
		end
	end

	// level must differ across two reference ticks before it is believed
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flvl <= 1'b0;
			stable <= 2'h0;
		end else if (s2 == flvl) begin
			stable <= 2'h0;
		end else if (tick) begin
			stable <= (stable == FILT_TICKS - 2'h1) ? 2'h0 : stable + 2'h1;
			flvl <= (stable == FILT_TICKS - 2'h1) ? s2 : flvl;
		end
	end

	assign raw_rise = s2 & ~s3;
	assign raw_toggle = s2 ^ s3;
	assign filt_rise = flvl & ~fprev;
endmodule
`default_nettype wire

// ==== design/fan_speed_monitor_ctrl.sv ====
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fan_speed_monitor_ctrl
	import fan_mon_pkg::*;
#(
	parameter int AW = 8,
	parameter int DIV = REF_DIV
) (
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          fan_in,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic               irq
);
	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	ctrl_s       ctrl;
	stat_s       stat;
	meas_e       state;
	logic [15:0] reading;
	logic [15:0] cnt;
	logic [15:0] high_lim;
	logic [15:0] low_lim;
	logic [3:0]  seen;
	logic        aw_full;
	logic        w_full;
	logic [AW-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        tick;
	logic        raw_rise;
	logic        raw_toggle;
	logic        filt_rise;

	ref_tick_div #(
		.DIV (DIV)
	) u_div (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.tick    (tick)
	);

	fan_edge_sync u_sync (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.tick       (tick),
		.fan_in     (fan_in),
		.raw_rise   (raw_rise),
		.raw_toggle (raw_toggle),
		.filt_rise  (filt_rise)
	);

	// ---- register bus
	wire do_wr = aw_full & w_full & ~s_axi_bvalid;
	wire wr_ctrl = hit(aw_addr, OFF_CTRL);
	wire wr_stat = hit(aw_addr, OFF_STAT);
	wire wr_high = hit(aw_addr, OFF_HIGH);
	wire wr_low = hit(aw_addr, OFF_LOW);
	wire wr_map = wr_ctrl | wr_stat | wr_high | wr_low;
	wire rd_ctrl = hit(s_axi_araddr, OFF_CTRL);
	wire rd_stat = hit(s_axi_araddr, OFF_STAT);
	wire rd_high = hit(s_axi_araddr, OFF_HIGH);
	wire rd_low = hit(s_axi_araddr, OFF_LOW);
	wire rd_map = rd_ctrl | rd_stat | rd_high | rd_low;
	wire ar_go = s_axi_arvalid & s_axi_arready;

	// reading bits sit in [31:16] and a control write takes only the control fields, so writes cannot reach them
	wire [31:0] ctrl_word = {reading, ctrl.in_en, ctrl.rdy_en, 1'b0, ctrl.edges,
		ctrl.mode, 1'b0, ctrl.filt, 6'h00, ctrl.en, ctrl.lim_en};
	wire [31:0] stat_word = {29'h0000_0000, stat};
	wire [31:0] wr_val = merge(ctrl_word, w_data, w_strb);
	wire [31:0] wr_lim_h = merge({16'h0000, high_lim}, w_data, w_strb);
	wire [31:0] wr_lim_l = merge({16'h0000, low_lim}, w_data, w_strb);
	wire [31:0] rd_mux = rd_ctrl ? ctrl_word :
		rd_stat ? stat_word :
		rd_high ? {16'h0000, high_lim} :
		rd_low ? {16'h0000, low_lim} : 32'h0000_0000;

	assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_full <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_wr) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			w_full <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_full <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_wr) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '0;
		end else if (do_wr & wr_ctrl) begin
			ctrl.in_en <= wr_val[BIT_IN_EN];
			ctrl.rdy_en <= wr_val[BIT_RDY_EN];
			ctrl.edges <= wr_val[EDGE_LSB +: 2];
			ctrl.mode <= wr_val[BIT_MODE];
			ctrl.filt <= wr_val[BIT_FILT];
			ctrl.en <= wr_val[BIT_EN];
			ctrl.lim_en <= wr_val[BIT_LIM_EN];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			high_lim <= HIGH_RST;
			low_lim <= LOW_RST;
		end else if (do_wr & wr_high) begin
			high_lim <= wr_lim_h[15:0];
		end else if (do_wr & wr_low) begin
			low_lim <= wr_lim_l[15:0];
		end
	end

	// ---- measurement
	wire run = ctrl.en;
	wire q_rise = ctrl.filt ? filt_rise : raw_rise;
	wire m0_inc = run & ~ctrl.mode & raw_rise;
	wire in_gate = (state == M_GATE);
	wire gate_edge = run & ctrl.mode & q_rise;
	wire tick_g = run & ctrl.mode & tick & in_gate;
	wire done_edge = gate_edge & in_gate & (seen + EDGE_ONE == edges_target(ctrl.edges));
	wire sat = tick_g & ~done_edge & (cnt == COUNT_MAX - COUNT_ONE);
	wire latch = done_edge | sat;
	wire upd = m0_inc | latch;
	// saturation reports all ones so a high limit below it trips
	wire [15:0] next_read = m0_inc ? cnt + COUNT_ONE : sat ? COUNT_MAX : cnt;
	wire [15:0] next_cnt = m0_inc ? cnt + COUNT_ONE :
		latch ? COUNT_ZERO :
		tick_g ? cnt + COUNT_ONE :
		(gate_edge & state == M_WAIT) ? COUNT_ZERO : cnt;
	wire lim_hit = upd & ((next_read > high_lim) | (next_read < low_lim));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= M_IDLE;
			seen <= 4'h0;
		end else if (!ctrl.mode) begin
			state <= M_IDLE;
			seen <= 4'h0;
		end else if (run) begin
			case (state)
				M_IDLE: begin
					state <= M_WAIT;
				end
				M_WAIT: begin
					if (gate_edge) begin
						state <= M_GATE;
						seen <= EDGE_ONE;
					end
				end
				M_GATE: begin
					if (done_edge) begin
						seen <= EDGE_ONE;  // closing edge opens the next interval
					end else if (sat) begin
						state <= M_WAIT;
						seen <= 4'h0;
					end else if (gate_edge) begin
						seen <= seen + EDGE_ONE;
					end
				end
				default: begin
					state <= M_IDLE;
					seen <= 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cnt <= COUNT_ZERO;
		else
			cnt <= next_cnt;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			reading <= COUNT_ZERO;
		else if (upd)
			reading <= next_read;
	end

	// ---- status and interrupt; a set in the clearing cycle wins
	wire [2:0] st_set = {run & raw_toggle, latch, lim_hit};
	wire [2:0] st_clr = (do_wr & wr_stat) ? wr_val[2:0] & {3{w_strb[0]}} : 3'h0;
	wire [2:0] st_mask = {ctrl.in_en, ctrl.rdy_en, ctrl.lim_en};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			stat <= '0;
		else
			stat <= (stat & ~st_clr) | st_set;
	end

	assign irq = |(stat & st_mask);

	// ---- checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	ro_reading_a: assert property (do_wr && wr_ctrl && !upd |=> $stable(reading))
		else $error("control write changed the reading");
	free_inc_a: assert property (m0_inc |=> reading == $past(cnt) + COUNT_ONE)
		else $error("free-running reading not updated on edge");
	free_wrap_a: assert property (m0_inc && cnt == COUNT_MAX |=> cnt == COUNT_ZERO)
		else $error("free-running counter did not wrap");
	sat_latch_a: assert property (sat |=> reading == COUNT_MAX && stat.rdy)
		else $error("saturation did not latch all ones");
	latch_clear_a: assert property (latch |=> cnt == COUNT_ZERO)
		else $error("counter not cleared after latch");
	stall_limit_a: assert property (sat && high_lim < COUNT_MAX |=> stat.lim)
		else $error("stall did not raise limit flag");
	edge_close_a: assert property (done_edge |=> state == M_GATE && seen == EDGE_ONE)
		else $error("interval did not restart at closing edge");
	gate_start_a: assert property (
		state == M_WAIT && gate_edge |=> in_gate && cnt == COUNT_ZERO)
		else $error("gate did not open on first edge");
	ready_flag_a: assert property (latch |=> stat.rdy)
		else $error("count ready not set on latch");
	limit_flag_a: assert property (upd && next_read > high_lim |=> stat.lim)
		else $error("limit flag missed");
	hold_off_a: assert property (!run |=> $stable(cnt) && $stable(reading))
		else $error("counters moved while idle");
	toggle_irq_a: assert property (stat.tog && ctrl.in_en |-> irq)
		else $error("toggle interrupt not raised");
	ready_irq_a: assert property (stat.rdy && ctrl.rdy_en |-> irq)
		else $error("count ready interrupt not raised");
	irq_quiet_a: assert property (!(|(stat & st_mask)) |-> !irq)
		else $error("interrupt without enabled flag");
	low_limit_a: assert property (upd && next_read < low_lim |=> stat.lim)
		else $error("low limit flag missed");
	lim_irq_a: assert property (stat.lim && ctrl.lim_en |-> irq)
		else $error("limit interrupt not raised");
	gate_tick_a: assert property (
		tick_g && !latch |=> cnt == $past(cnt) + COUNT_ONE)
		else $error("gate tick not counted");
	sat_rearm_a: assert property (sat |=> state == M_WAIT && seen == 4'h0)
		else $error("saturation did not rearm the gate");
	wait_hold_a: assert property (
		state == M_WAIT && ctrl.mode && !gate_edge |=> $stable(cnt))
		else $error("counter moved before the gate opened");
	mode_free_a: assert property (!ctrl.mode |=> state == M_IDLE)
		else $error("gate state kept in free-running mode");
	free_hold_a: assert property (run && !ctrl.mode && !raw_rise |=> $stable(cnt))
		else $error("free-running counter moved without an edge");
	toggle_set_a: assert property (run && raw_toggle |=> stat.tog)
		else $error("input toggle flag missed");
	irq_off_a: assert property (!ctrl.in_en && !ctrl.rdy_en && !ctrl.lim_en |-> !irq)
		else $error("interrupt with every enable clear");
	rd_ctrl_a: assert property (ar_go && rd_ctrl |=> s_axi_rdata == $past(ctrl_word))
		else $error("control read returned stale data");
	wr_mode_a: assert property (
		do_wr && wr_ctrl |=> ctrl.mode == $past(wr_val[BIT_MODE]))
		else $error("mode bit not written");

	gate_done_c: cover property (done_edge);
	gate_sat_c: cover property (sat);
	free_wrap_c: cover property (m0_inc && cnt == COUNT_MAX);
	irq_clear_c: cover property (irq ##1 do_wr && wr_stat ##1 !irq);
	filt_gate_c: cover property (gate_edge && ctrl.filt);
endmodule
`default_nettype wire

// ==== verif/fan_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module fan_model (
	input  wire logic clk_sys,
	output logic      fan_out
);
	initial fan_out = 1'b0;

	// push-pull output; rests low between bursts so no edge leaks out
	task automatic pulses(input int n, input int half);
		repeat (n) begin
			fan_out <= 1'b1;
			repeat (half) @(posedge clk_sys);
			fan_out <= 1'b0;
			repeat (half) @(posedge clk_sys);
		end
	endtask
endmodule
`default_nettype wire

// ==== verif/test_fan_speed_monitor_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_fan_speed_monitor_ctrl
	import fan_mon_pkg::*;
;
	logic        clk_sys, rst_n, fan_in;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
	int          err_count, comparisons, seed, n, half;
	int          ne[4] = '{2, 3, 5, 9};

	// one tick per clock so a full saturation fits a short run
	fan_speed_monitor_ctrl #(.DIV(1)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .fan_in(fan_in),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));

	fan_model fan (.clk_sys(clk_sys), .fan_out(fan_in));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready) begin
				aw = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// a spare edge so the next call never re-drives bready in this step
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (!s_axi_rvalid);
		q = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	// gated reading spans edges-1 periods; edge cycles may drop a tick
	function automatic int gate_span(input int e, input int h);
		return (e - 1) * 2 * h;
	endfunction

	// only the documented control bits read back; the reading is zero here
	function automatic logic [31:0] ctrl_back(input logic [31:0] d);
		return d & 32'h0000_dd03;
	endfunction

	task automatic meas_check(input int e, input int h);
		int v;
		rd(OFF_CTRL);
		v = int'(q[31:16]);
		check(v >= gate_span(e, h) - e && v <= gate_span(e, h) + 1, 1);
	endtask

	// irq is settled from the previous cycle when a task returns
	task automatic irq_is(input logic exp);
		check(irq, exp);
	endtask

	initial begin
		repeat (90000) @(posedge clk_sys);
		err_count++;
		test_done();
	end

	initial begin
		seed = 84;
		err_count = 0;
		comparisons = 0;
		rst_n = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(OFF_CTRL);
		check(q, 32'h0000_0000);
		rd(OFF_HIGH);
		check(q, {16'h0000, HIGH_RST});
		rd(8'h10);
		check(r, RESP_SLVERR);
		wr(8'h10, 32'hffff_ffff);
		check(r, RESP_SLVERR);
		for (int i = 0; i < 5; i++) begin
			q = (i == 0) ? 32'hffff_ffff : $random(seed);
			wr(OFF_CTRL, q);
			rd(OFF_CTRL);
			check(q, ctrl_back(s_axi_wdata));
		end
		// free-running edge count, held while disabled
		n = 1 + int'($unsigned($random(seed)) % 8);
		wr(OFF_CTRL, 32'h0000_0002);
		wr(OFF_STAT, 32'h0000_0007);
		fan.pulses(n, 5);
		rd(OFF_CTRL);
		check(q[31:16], n[15:0]);
		rd(OFF_CTRL);
		check(q[31:16], n[15:0]);
		wr(OFF_CTRL, 32'h0000_0000);
		fan.pulses(3, 5);
		rd(OFF_CTRL);
		check(q[31:16], n[15:0]);
		wr(OFF_CTRL, 32'h0000_0002);
		fan.pulses(2, 5);
		rd(OFF_CTRL);
		check(q[31:16], n[15:0] + 16'h0002);
		rd(OFF_STAT);
		check(q[2], 1'b1);
		irq_is(1'b0);
		wr(OFF_CTRL, 32'h0000_8002);
		irq_is(1'b1);
		wr(OFF_STAT, 32'h0000_0004);
		irq_is(1'b0);
		// gated tick count for every edge selection, odd ones through the filter
		for (int s = 0; s < 4; s++) begin
			half = 10 + int'($unsigned($random(seed)) % 16);
			wr(OFF_CTRL, 32'h0000_0002);
			wr(OFF_STAT, 32'h0000_0007);
			wr(OFF_CTRL, 32'h0000_4402 | (s << EDGE_LSB) | ((s & 1) << BIT_FILT));
			irq_is(1'b0);
			fan.pulses(ne[s], half);
			meas_check(ne[s], half);
			rd(OFF_STAT);
			check(q[1], 1'b1);
			irq_is(1'b1);
		end
		// stalled fan: one edge then silence until saturation
		wr(OFF_CTRL, 32'h0000_0002);
		wr(OFF_HIGH, 32'h0000_0100);
		wr(OFF_STAT, 32'h0000_0007);
		wr(OFF_CTRL, 32'h0000_0403);
		fan.pulses(1, 10);
		repeat (65600) @(posedge clk_sys);
		rd(OFF_CTRL);
		check(q[31:16], COUNT_MAX);
		rd(OFF_STAT);
		check(q[0], 1'b1);
		irq_is(1'b1);
		// short interval under a raised low limit; counting restarts at zero
		wr(OFF_HIGH, 32'h0000_ffff);
		wr(OFF_LOW, 32'h0000_0100);
		wr(OFF_STAT, 32'h0000_0007);
		fan.pulses(2, 10);
		meas_check(2, 10);
		rd(OFF_STAT);
		check(q[0], 1'b1);
		irq_is(1'b1);
		test_done();
	end
endmodule
`default_nettype wire
